/* File: hw/psil_pkg.sv */
// Package of register map constants for the PLL status interrupt logic
// Notes on behaviour
// RL1: Enabled synth lock-loss latch pulls irq low
// RL2: Enabled VCXO lock-loss latch pulls irq low
// RL3: Enabled input LOS latch pulls irq low
// RL4: Enabled reference-loss latch pulls irq low
// RL5: Enabled holdover latch pulls irq low
// RL6: Enables reset to zero; disabled latches ignored
// RL7: Synth sticky lock reads 0 after event
// RL8: Write one clears synth latch and interrupt
// RL9: VCXO sticky lock reads 0 after event
// RL10: Write one clears VCXO latch and interrupt
// RL11: Input sticky activity reads 0 after LOS
// RL12: Write one clears input latch and interrupt
// RL13: Selected input bit shows machine's choice
// RL14: Live lock bits follow lock, unlatched
// RL15: Live activity bits follow input LOS
// RL16: Sticky reference reads 0 after loss
// RL17: Write one clears reference latch and interrupt
// RL18: Live reference bit shows reference present
// RL19: Sticky holdover reads 0 after holdover entry
// RL20: Write one clears holdover latch and interrupt
// RL21: Live holdover bit low during holdover
// RL22: Calibration bit high while calibration runs
// RL23: Irq returns high when nothing enabled pending
// RL24: Reserved bits read zero, writes ignored
package psil_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;
    // Register offsets
    localparam logic [7:0] IRQ_ENABLE_MASK_ADDR = 8'h4c;
    localparam logic [7:0] LATCHED_EVENT_STATUS_ADDR = 8'h50;
    localparam logic [7:0] LIVE_CONDITION_STATUS_ADDR = 8'h51;
    localparam logic [7:0] CALIBRATION_STATUS_ADDR = 8'h53;
    // Field positions of the enable, latched and live registers; BIT_SELECT is live only, BIT_CAL is in the calibration register
    localparam int unsigned BIT_INPUT0 = 0;
    localparam int unsigned BIT_INPUT1 = 1;
    localparam int unsigned BIT_HOLDOVER = 2;
    localparam int unsigned BIT_REF = 3;
    localparam int unsigned BIT_VCXO = 4;
    localparam int unsigned BIT_SYNTH = 5;
    localparam int unsigned BIT_SELECT = 6;
    localparam int unsigned BIT_CAL = 2;
    localparam int unsigned NUM_EVENTS = 6;
    // Reset values
    localparam logic [5:0] IRQ_ENABLE_RESET = 6'h00;
    localparam logic [5:0] EVENT_RESET = 6'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
endpackage

/* File: hw/psil_top.sv */
// Status latches, enables and interrupt output for the PLL status logic
`timescale 1ns/1ps
module psil_top #(
    parameter int unsigned DATA_W = psil_pkg::DATA_W
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port from the serial configuration engine
    input wire logic [psil_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [DATA_W-1:0] reg_rdata,
    // Live conditions from the monitors
    input wire logic synth_lock_live,
    input wire logic vcxo_lock_live,
    input wire logic ref_present_live,
    input wire logic holdover_live,
    input wire logic [1:0] input_active_live,
    input wire logic selected_input_live,
    input wire logic synth_cal_running,
    // Interrupt pin
    output logic irq_out_n
);
    // Elaboration checks on what the logic can serve
    if (DATA_W != 8) begin : g_data_width_check
        $error("psil_top supports only 8-bit register data");
    end

    if (psil_pkg::ADDR_W != 8) begin : g_addr_width_check
        $error("psil_top decodes 8-bit register addresses only");
    end

    if (psil_pkg::NUM_EVENTS != 6) begin : g_event_count_check
        $error("psil_top serves exactly six event latches");
    end

    // Reset release
    logic rst_meta_n;
    logic rst_sync_n;

    // Register port decode
    logic hit_enable;
    logic hit_latched;
    logic hit_live;
    logic hit_cal;
    logic wr_enable_reg;
    logic wr_latched_reg;
    logic [5:0] clear_mask;

    // Interrupt enables
    logic [5:0] irq_en;
    logic [5:0] next_irq_en;

    // Conditions lost in this cycle
    logic synth_lost;
    logic vcxo_lost;
    logic ref_lost;
    logic hold_entered;
    logic [1:0] input_lost;

    // Sticky latches, 1 meaning an event was recorded
    logic synth_latch;
    logic vcxo_latch;
    logic ref_latch;
    logic hold_latch;
    logic input0_latch;
    logic input1_latch;
    logic next_synth_latch;
    logic next_vcxo_latch;
    logic next_ref_latch;
    logic next_hold_latch;
    logic next_input0_latch;
    logic next_input1_latch;
    logic [5:0] event_latched;

    // Interrupt and read path
    logic [5:0] pending;
    logic irq_pending;
    logic next_irq_n;
    logic [7:0] image_enable;
    logic [7:0] image_latched;
    logic [7:0] image_live;
    logic [7:0] image_cal;
    logic [7:0] next_rdata;

    // True when the port address selects the given register
    function automatic logic addr_is(
        input logic [psil_pkg::ADDR_W-1:0] addr,
        input logic [7:0] target
    );
        return addr == target;
    endfunction

    // A new event beats a write-one clear, so none is lost
    function automatic logic sticky_next(
        input logic held,
        input logic lost,
        input logic clear
    );
        return (held & ~clear) | lost;
    endfunction

    // An event counts for the pin only where its enable is set
    function automatic logic armed(
        input logic [5:0] latched,
        input logic [5:0] en,
        input int unsigned pos
    );
        return latched[pos] & en[pos];
    endfunction

    // Enable image; reserved upper bits read 0
    function automatic logic [7:0] pack_enable(
        input logic [5:0] en
    );
        logic [7:0] img;
        img = psil_pkg::RDATA_RESET;
        img[5:0] = en;
        return img;
    endfunction

    // Latched image reads 0 where an event was recorded
    function automatic logic [7:0] pack_latched(
        input logic [5:0] latched
    );
        logic [7:0] img;
        img = psil_pkg::RDATA_RESET;
        img[5:0] = ~latched;
        return img;
    endfunction

    // Live image, shown as presented by the monitors
    function automatic logic [7:0] pack_live(
        input logic sel,
        input logic synth_ok,
        input logic vcxo_ok,
        input logic ref_ok,
        input logic hold_ok,
        input logic [1:0] active
    );
        logic [7:0] img;
        img = psil_pkg::RDATA_RESET;
        img[psil_pkg::BIT_SELECT] = sel; // see RL13
        img[psil_pkg::BIT_SYNTH] = synth_ok; // see RL14
        img[psil_pkg::BIT_VCXO] = vcxo_ok; // see RL14
        img[psil_pkg::BIT_REF] = ref_ok; // see RL18
        img[psil_pkg::BIT_HOLDOVER] = hold_ok; // see RL21
        img[psil_pkg::BIT_INPUT0] = active[0]; // see RL15
        img[psil_pkg::BIT_INPUT1] = active[1]; // see RL15
        return img;
    endfunction

    // Calibration image; only the running flag is defined
    function automatic logic [7:0] pack_cal(
        input logic running
    );
        logic [7:0] img;
        img = psil_pkg::RDATA_RESET;
        img[psil_pkg::BIT_CAL] = running; // see RL22
        return img;
    endfunction

    // Reset release through two stages; assertion stays asynchronous
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // Address decode, shared by the write strobes and the read mux
    always_comb begin
        hit_enable = addr_is(reg_addr, psil_pkg::IRQ_ENABLE_MASK_ADDR);
        hit_latched = addr_is(reg_addr, psil_pkg::LATCHED_EVENT_STATUS_ADDR);
        hit_live = addr_is(reg_addr, psil_pkg::LIVE_CONDITION_STATUS_ADDR);
        hit_cal = addr_is(reg_addr, psil_pkg::CALIBRATION_STATUS_ADDR);
    end

    // Write strobes
    always_comb begin
        wr_enable_reg = reg_wr_en && hit_enable;
        wr_latched_reg = reg_wr_en && hit_latched;
    end

    // Write-one clear mask; reserved bits 7:6 are dropped
    always_comb begin
        clear_mask = '0;
        if (wr_latched_reg) begin
            clear_mask = reg_wdata[5:0]; // see RL24
        end
    end

    // Next enable value; reserved bits 7:6 are dropped
    always_comb begin
        next_irq_en = irq_en;
        if (wr_enable_reg) begin
            next_irq_en = reg_wdata[5:0]; // see RL24
        end
    end

    // Interrupt enables
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_en <= psil_pkg::IRQ_ENABLE_RESET; // see RL6
        end else begin
            irq_en <= next_irq_en;
        end
    end

    // A level 0 from a monitor means the condition is lost
    always_comb begin
        synth_lost = ~synth_lock_live;
        vcxo_lost = ~vcxo_lock_live;
        ref_lost = ~ref_present_live;
        hold_entered = ~holdover_live;
        input_lost = ~input_active_live;
    end

    // Synthesizer lock-loss latch
    always_comb begin
        next_synth_latch = sticky_next(synth_latch, synth_lost,
            clear_mask[psil_pkg::BIT_SYNTH]); // see RL8
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            synth_latch <= psil_pkg::EVENT_RESET[psil_pkg::BIT_SYNTH];
        end else begin
            synth_latch <= next_synth_latch; // see RL7
        end
    end

    // VCXO lock-loss latch
    always_comb begin
        next_vcxo_latch = sticky_next(vcxo_latch, vcxo_lost,
            clear_mask[psil_pkg::BIT_VCXO]); // see RL10
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            vcxo_latch <= psil_pkg::EVENT_RESET[psil_pkg::BIT_VCXO];
        end else begin
            vcxo_latch <= next_vcxo_latch; // see RL9
        end
    end

    // Reference-loss latch
    always_comb begin
        next_ref_latch = sticky_next(ref_latch, ref_lost,
            clear_mask[psil_pkg::BIT_REF]); // see RL17
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ref_latch <= psil_pkg::EVENT_RESET[psil_pkg::BIT_REF];
        end else begin
            ref_latch <= next_ref_latch; // see RL16
        end
    end

    // Holdover entry latch
    always_comb begin
        next_hold_latch = sticky_next(hold_latch, hold_entered,
            clear_mask[psil_pkg::BIT_HOLDOVER]); // see RL20
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hold_latch <= psil_pkg::EVENT_RESET[psil_pkg::BIT_HOLDOVER];
        end else begin
            hold_latch <= next_hold_latch; // see RL19
        end
    end

    // First clock input loss-of-signal latch
    always_comb begin
        next_input0_latch = sticky_next(input0_latch, input_lost[0],
            clear_mask[psil_pkg::BIT_INPUT0]); // see RL12
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            input0_latch <= psil_pkg::EVENT_RESET[psil_pkg::BIT_INPUT0];
        end else begin
            input0_latch <= next_input0_latch; // see RL11
        end
    end

    // Second clock input loss-of-signal latch
    always_comb begin
        next_input1_latch = sticky_next(input1_latch, input_lost[1],
            clear_mask[psil_pkg::BIT_INPUT1]); // see RL12
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            input1_latch <= psil_pkg::EVENT_RESET[psil_pkg::BIT_INPUT1];
        end else begin
            input1_latch <= next_input1_latch; // see RL11
        end
    end

    // Latched events gathered at their field positions
    always_comb begin
        event_latched = psil_pkg::EVENT_RESET;
        event_latched[psil_pkg::BIT_SYNTH] = synth_latch;
        event_latched[psil_pkg::BIT_VCXO] = vcxo_latch;
        event_latched[psil_pkg::BIT_REF] = ref_latch;
        event_latched[psil_pkg::BIT_HOLDOVER] = hold_latch;
        event_latched[psil_pkg::BIT_INPUT1] = input1_latch;
        event_latched[psil_pkg::BIT_INPUT0] = input0_latch;
    end

    // Pending events; a disabled latch never reaches the pin
    always_comb begin
        pending = '0;
        pending[psil_pkg::BIT_SYNTH] =
            armed(event_latched, irq_en, psil_pkg::BIT_SYNTH); // see RL1
        pending[psil_pkg::BIT_VCXO] =
            armed(event_latched, irq_en, psil_pkg::BIT_VCXO); // see RL2
        pending[psil_pkg::BIT_REF] =
            armed(event_latched, irq_en, psil_pkg::BIT_REF); // see RL4
        pending[psil_pkg::BIT_HOLDOVER] =
            armed(event_latched, irq_en, psil_pkg::BIT_HOLDOVER); // see RL5
        pending[psil_pkg::BIT_INPUT1] =
            armed(event_latched, irq_en, psil_pkg::BIT_INPUT1); // see RL3
        pending[psil_pkg::BIT_INPUT0] =
            armed(event_latched, irq_en, psil_pkg::BIT_INPUT0); // see RL3
    end

    always_comb begin
        irq_pending = |pending; // see RL6
        next_irq_n = ~irq_pending; // see RL23
    end

    // Registered so the pin cannot glitch, at one cycle of latency
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= next_irq_n;
        end
    end

    always_comb begin
        image_enable = pack_enable(irq_en);
    end

    always_comb begin
        image_latched = pack_latched(event_latched);
    end

    always_comb begin
        image_live = pack_live(selected_input_live, synth_lock_live,
            vcxo_lock_live, ref_present_live, holdover_live,
            input_active_live);
    end

    always_comb begin
        image_cal = pack_cal(synth_cal_running);
    end

    // Read mux; unmapped addresses read 0
    always_comb begin
        next_rdata = psil_pkg::RDATA_RESET; // see RL24
        if (hit_enable) begin
            next_rdata = image_enable;
        end else if (hit_latched) begin
            next_rdata = image_latched;
        end else if (hit_live) begin
            next_rdata = image_live;
        end else if (hit_cal) begin
            next_rdata = image_cal;
        end
    end

    // Read data holds until the next read strobe
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= psil_pkg::RDATA_RESET;
        end else if (reg_rd_en) begin
            reg_rdata <= next_rdata;
        end
    end
endmodule // psil_top

/* File: tb/psil_cond_model.sv */
// Monitor model driving the live levels
`timescale 1ns/1ps
module psil_cond_model (
    input wire logic [7:0] want,
    output logic [7:0] cond
);
    assign cond = want;
endmodule // psil_cond_model

/* File: tb/psil_monitor.sv */
// Checker on the status block ports
`timescale 1ns/1ps
module psil_mon (
    input wire logic sys_clk, reset_n, reg_wr_en, reg_rd_en, irq_out_n,
    input wire logic synth_lock_live, ref_present_live, synth_cal_running,
    input wire logic selected_input_live,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata
);
    logic [5:0] en;
    logic [1:0] rst_q;
    // Block leaves reset two edges after the pin; follow it
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n) rst_q <= 2'b00;
        else rst_q <= {rst_q[0], 1'b1};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_q[1]);
    // Enable shadow ties irq to the writes
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n) en <= 6'h00;
        else if (reg_wr_en && reg_addr == 8'h4c) en <= reg_wdata[5:0];
    sequence s_rd(a); reg_rd_en && reg_addr == a; endsequence
    sequence s_loss(c, e); !c ##1 e; endsequence
    property p_sel; s_rd(8'h51) |=>
        reg_rdata[7:6] == {1'b0, $past(selected_input_live)}; endproperty
    property p_cal; s_rd(8'h53) |=>
        reg_rdata == {5'h00, $past(synth_cal_running), 2'h0}; endproperty
    property p_void; reg_rd_en && !(reg_addr inside {8'h4c, 8'h50, 8'h51,
        8'h53}) |=> reg_rdata == 8'h00; endproperty
    property p_resv; s_rd(8'h4c) |=> reg_rdata[7:6] == 2'h0; endproperty
    property p_stk; !synth_lock_live ##1 s_rd(8'h50) |=> !reg_rdata[5];
    endproperty
    property p_masked; $past(en) == 6'h00 |-> irq_out_n; endproperty
    property p_synth_irq; s_loss(synth_lock_live, en[5]) |=> !irq_out_n;
    endproperty
    property p_ref_irq; s_loss(ref_present_live, en[3]) |=> !irq_out_n;
    endproperty
    a_sel: assert property (p_sel) else $error("select");
    a_cal: assert property (p_cal) else $error("cal");
    a_void: assert property (p_void) else $error("unmapped");
    a_resv: assert property (p_resv) else $error("reserved");
    a_stk: assert property (p_stk) else $error("sticky");
    a_masked: assert property (p_masked) else $error("masked");
    a_synth_irq: assert property (p_synth_irq) else $error("irq");
    a_ref_irq: assert property (p_ref_irq) else $error("irq");
endmodule // psil_mon
bind psil_top psil_mon u_mon (.*);

/* File: tb/tb_psil_top.sv */
// Bench for the status block
`timescale 1ns/1ps
module tb_psil_top;
    logic sys_clk = 0, reset_n = 0, reg_wr_en = 0, reg_rd_en = 0;
    logic irq_out_n, synth_lock_live, vcxo_lock_live, ref_present_live;
    logic holdover_live, selected_input_live, synth_cal_running;
    logic [1:0] input_active_live;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, want = 8'h3f;
    logic [7:0] reg_rdata, got, m;
    int n_mismatch = 0, n_tests = 0, cyc_n = 0;
    logic [23:0] rows [9] = '{24'h3f513f, 24'h7f517f, 24'h1f511f,
        24'h2f512f, 24'h3c513c, 24'h375137, 24'h3b513b, 24'hbf5304,
        24'h3f5200};
    psil_cond_model u_cond (.want(want), .cond({synth_cal_running,
        selected_input_live, synth_lock_live, vcxo_lock_live,
        ref_present_live, holdover_live, input_active_live}));
    psil_top u_dut (.*);
    initial forever #25 sys_clk = ~sys_clk;
    task automatic tick; @(posedge sys_clk); #5; endtask
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] seen);
        n_tests++;
        if (seen !== exp) n_mismatch++;
        if (seen !== exp) $display("mismatch %s %h %h", nm, exp, seen);
    endtask
    task automatic wr(logic [7:0] a, d);
        reg_addr = a; reg_wdata = d; reg_wr_en = 1; tick; reg_wr_en = 0;
    endtask
    task automatic rd(logic [7:0] a);
        reg_addr = a; reg_rd_en = 1; tick; reg_rd_en = 0; got = reg_rdata;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge sys_clk) if (++cyc_n == 400) begin
        n_mismatch++;
        final_report;
    end
    initial begin
        repeat (16) tick;
        reset_n = 1;
        repeat (3) tick;
        rd(8'h4c);
        chk("en", 8'h00, got);
        for (int i = 0; i < 9; i++) begin
            tick; want = rows[i][23:16]; rd(rows[i][15:8]);
            chk("row", rows[i][7:0], got);
        end
        wr(8'h50, 8'hff); rd(8'h50);
        chk("sticky", 8'h3f, got);
        wr(8'h4c, 8'hff); rd(8'h4c);
        chk("en", 8'h3f, got);
        for (int b = 0; b < 6; b++) begin
            m = 8'h01 << b;
            want = 8'h3f ^ m; wr(8'h4c, 8'h00); want = 8'h3f; rd(8'h50);
            chk("sticky", 8'h3f ^ m, got);
            chk("masked", 8'h01, {7'h0, irq_out_n});
            want = 8'h3f ^ m; wr(8'h4c, m); want = 8'h3f; tick;
            chk("raised", 8'h00, {7'h0, irq_out_n});
            wr(8'h50, m); tick;
            chk("clr", 8'h01, {7'h0, irq_out_n});
        end
        // Clear while the loss persists: the set wins
        want = 8'h1f; wr(8'h50, 8'h20); rd(8'h50);
        chk("setwin", 8'h1f, got);
        chk("irq", 8'h00, {7'h0, irq_out_n});
        // Reset in mid-run
        reset_n = 0; want = 8'h3f; repeat (2) tick;
        chk("rst irq", 8'h01, {7'h0, irq_out_n});
        chk("rst data", 8'h00, reg_rdata);
        reset_n = 1; repeat (3) tick;
        rd(8'h4c);
        chk("en", 8'h00, got);
        tick; rd(8'h50);
        chk("sticky", 8'h3f, got);
        final_report;
    end
endmodule // tb_psil_top
